// file: hw/idr_map.vh
// What this block does
// - Every accepted identify request returns exactly 4096 bytes.
// - List space not filled with entries is returned as zeros.
// - A selector that is not implemented aborts with Invalid Field in Command.
// - Selector 00h on a non-broadcast id returns the namespace description if active, else all zeros.
// - Selector 01h returns the controller description of this controller.
// - Selector 02h returns up to 32 active ids (1h to 20h), ascending, above the given id.
// - Selector 02h with a broadcast-class id aborts with Invalid Namespace.
// - Selector 02h with id zero starts the list at namespace 1h.
// - Selector 03h on an active namespace returns descriptors within the payload.
// - Bytes after the last descriptor are zero; a zero length ends the list.
// - No descriptor type repeats and one descriptor identifies the namespace.
`ifndef IDR_MAP_VH
`define IDR_MAP_VH
// Register byte offsets
`define IDR_REG_CTRL 8'h00
`define IDR_REG_SELECTOR 8'h04
`define IDR_REG_NAMESPACE_IDENTIFIER 8'h08
`define IDR_REG_ACTIVE 8'h0c
`define IDR_REG_CONFIG 8'h10
`define IDR_REG_STATUS 8'h14
`define IDR_REG_INT_STATUS 8'h18
`define IDR_REG_INT_MASK 8'h1c
// Field positions
`define IDR_CTRL_START 0
`define IDR_CFG_NS_MGMT 0
`define IDR_ST_BUSY 0
`define IDR_ST_CODE_LO 8
`define IDR_INT_DONE 0
`define IDR_INT_ABORT 1
// Buffer size in 32-bit words (4096 bytes)
`define IDR_BUF_WORDS 11'h400
`define IDR_LAST_INDEX 10'h3ff
// Selector values
`define IDR_SEL_NAMESPACE 8'h00
`define IDR_SEL_CONTROLLER 8'h01
`define IDR_SEL_ACTIVE_LIST 8'h02
`define IDR_SEL_DESCRIPTORS 8'h03
// Identifiers
`define IDR_NAMESPACE_IDENTIFIER_BROADCAST 32'hffffffff
`define IDR_NAMESPACE_IDENTIFIER_BROADCAST_M1 32'hfffffffe
// Completion status codes
`define IDR_STATUS_OK 8'h00
`define IDR_STATUS_INVALID_FIELD 8'h02
`define IDR_STATUS_INVALID_NS 8'h0b
// Descriptor header: type 1, length 8 bytes
`define IDR_DESC_TYPE 8'h01
`define IDR_DESC_LENGTH 8'h08
// Reset values
`define IDR_RST_ACTIVE 32'h00000000
`define IDR_RST_CONFIG 32'h00000000
`define IDR_RST_WORD 32'h00000000
`endif

// file: hw/idr_responder.v
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "idr_map.vh"
module idr_responder #(
   // Arbitrary identity values for the returned descriptions
   parameter [31:0] NS_DESC_WORD = 32'h00001000,
   parameter [31:0] COMMON_DESC_WORD = 32'h0000c0de,
   parameter [31:0] CTRL_DESC_WORD = 32'h00005a5a,
   parameter [31:0] NS_EUI_HIGH = 32'h00a1b2c3
) (
   input wire clock,
   input wire reset,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   output reg buf_valid,
   output reg [9:0] buf_index,
   output reg [31:0] buf_data,
   output reg buf_last,
   output reg irq
);
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_SEND = 2'b01;

   reg [1:0] state;
   reg [7:0] selector;
   reg [31:0] namespace_identifier;
   reg [31:0] active;
   reg [31:0] config_bits;
   reg [7:0] last_status;
   reg [1:0] int_status;
   reg [1:0] int_mask;
   reg [1:0] mode;
   reg [10:0] word_count;
   reg [31:0] list_mask;
   reg [31:0] cmd_namespace_identifier;
   reg ph_write;
   reg ph_valid;
   reg [7:0] ph_addr;

   localparam [1:0] MODE_ZERO = 2'b00;
   localparam [1:0] MODE_WORD = 2'b01;
   localparam [1:0] MODE_LIST = 2'b10;
   localparam [1:0] MODE_DESC = 2'b11;

   wire addr_take;
   wire wr_now;
   wire start_req;
   wire ns_in_range;
   wire ns_active;
   wire is_broadcast;
   wire [4:0] ns_bit;

   // Address phase is taken when selected, NONSEQ or SEQ (htrans[1] set) and the bus is ready
   assign addr_take = hsel & htrans[1] & hready;
   assign wr_now = ph_valid & ph_write;
   assign start_req = wr_now & (ph_addr == `IDR_REG_CTRL) & hwdata[`IDR_CTRL_START];
   assign ns_in_range = (namespace_identifier != 32'h00000000) & (namespace_identifier <= 32'h00000020);
   assign ns_bit = namespace_identifier[4:0] - 5'h01;
   assign ns_active = ns_in_range & active[ns_bit];
   assign is_broadcast = (namespace_identifier == `IDR_NAMESPACE_IDENTIFIER_BROADCAST);

   // Active ids strictly above the command id; bit k stands for id k+1
   reg [31:0] above_mask;
   integer i;
   always @* begin
      above_mask = 32'h00000000;
      for (i = 0; i < 32; i = i + 1) begin
         if (namespace_identifier < (i + 1)) begin
            above_mask[i] = active[i];
         end
      end
   end

   // Lowest pending id of the list and the mask with it removed
   reg [31:0] list_id;
   reg [31:0] list_rest;
   integer j;
   always @* begin
      list_id = 32'h00000000;
      list_rest = list_mask;
      for (j = 31; j >= 0; j = j - 1) begin
         if (list_mask[j]) begin
            list_id = j + 1;
         end
      end
      if (list_id != 32'h00000000) begin
         list_rest[list_id[4:0] - 5'h01] = 1'b0;
      end
   end

   // Word to return at the current index for the chosen structure
   reg [31:0] next_word;
   always @* begin
      next_word = 32'h00000000;
      case (mode)
         MODE_WORD: begin
            if (word_count == 11'h000) begin
               next_word = cmd_namespace_identifier;
            end
         end
         MODE_LIST: begin
            next_word = list_id;
         end
         MODE_DESC: begin
            // One identifying descriptor, then zeros ending the list
            if (word_count == 11'h000) begin
               next_word = {16'h0000, `IDR_DESC_LENGTH, `IDR_DESC_TYPE};
            end else if (word_count == 11'h001) begin
               next_word = cmd_namespace_identifier;
            end else if (word_count == 11'h002) begin
               next_word = NS_EUI_HIGH;
            end else begin
               next_word = 32'h00000000;
            end
         end
         default: begin
            next_word = 32'h00000000;
         end
      endcase
   end

   // Decode of a start request: structure choice or abort code
   reg [7:0] next_status;
   reg [1:0] next_mode;
   reg [31:0] next_first;
   always @* begin
      next_status = `IDR_STATUS_OK;
      next_mode = MODE_ZERO;
      next_first = `IDR_RST_WORD;
      case (selector)
         `IDR_SEL_NAMESPACE: begin
            if (is_broadcast) begin
               if (config_bits[`IDR_CFG_NS_MGMT]) begin
                  next_mode = MODE_WORD;
                  next_first = COMMON_DESC_WORD;
               end else begin
                  next_status = `IDR_STATUS_INVALID_NS;
               end
            end else if (ns_active) begin
               next_mode = MODE_WORD;
               next_first = NS_DESC_WORD;
            end else begin
               next_mode = MODE_ZERO;
            end
         end
         `IDR_SEL_CONTROLLER: begin
            next_mode = MODE_WORD;
            next_first = CTRL_DESC_WORD;
         end
         `IDR_SEL_ACTIVE_LIST: begin
            if (is_broadcast | (namespace_identifier == `IDR_NAMESPACE_IDENTIFIER_BROADCAST_M1)) begin
               next_status = `IDR_STATUS_INVALID_NS;
            end else begin
               next_mode = MODE_LIST;
            end
         end
         `IDR_SEL_DESCRIPTORS: begin
            if (ns_active) begin
               next_mode = MODE_DESC;
            end else begin
               next_status = `IDR_STATUS_INVALID_NS;
            end
         end
         default: begin
            next_status = `IDR_STATUS_INVALID_FIELD;
         end
      endcase
   end

   // Bus slave: address phase capture, zero wait states, OKAY only
   always @(posedge clock) begin
      if (reset) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ph_valid <= addr_take;
         ph_write <= hwrite;
         ph_addr <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read data registered at the address phase; unmapped reads zero
   always @(posedge clock) begin
      if (reset) begin
         hrdata <= 32'h00000000;
      end else if (addr_take & ~hwrite) begin
         case (haddr[7:0])
            `IDR_REG_SELECTOR: hrdata <= {24'h000000, selector};
            `IDR_REG_NAMESPACE_IDENTIFIER: hrdata <= namespace_identifier;
            `IDR_REG_ACTIVE: hrdata <= active;
            `IDR_REG_CONFIG: hrdata <= config_bits;
            `IDR_REG_STATUS: begin
               hrdata <= {5'h00, word_count, last_status, 7'h00, state == ST_SEND};
            end
            `IDR_REG_INT_STATUS: hrdata <= {30'h00000000, int_status};
            `IDR_REG_INT_MASK: hrdata <= {30'h00000000, int_mask};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // Software registers; writes land in the data phase
   always @(posedge clock) begin
      if (reset) begin
         selector <= 8'h00;
         namespace_identifier <= 32'h00000000;
         active <= `IDR_RST_ACTIVE;
         config_bits <= `IDR_RST_CONFIG;
         int_mask <= 2'b00;
      end else if (wr_now) begin
         case (ph_addr)
            `IDR_REG_SELECTOR: selector <= hwdata[7:0];
            `IDR_REG_NAMESPACE_IDENTIFIER: namespace_identifier <= hwdata;
            `IDR_REG_ACTIVE: active <= hwdata;
            `IDR_REG_CONFIG: config_bits <= {31'h00000000, hwdata[0]};
            `IDR_REG_INT_MASK: int_mask <= hwdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // Command engine: decode on start, then stream the whole buffer
   always @(posedge clock) begin
      if (reset) begin
         state <= ST_IDLE;
         mode <= MODE_ZERO;
         word_count <= 11'h000;
         list_mask <= 32'h00000000;
         cmd_namespace_identifier <= 32'h00000000;
         last_status <= `IDR_STATUS_OK;
         buf_valid <= 1'b0;
         buf_index <= 10'h000;
         buf_data <= 32'h00000000;
         buf_last <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               buf_valid <= 1'b0;
               buf_last <= 1'b0;
               if (start_req) begin
                  last_status <= next_status;
                  if (next_status == `IDR_STATUS_OK) begin
                     state <= ST_SEND;
                     mode <= next_mode;
                     word_count <= 11'h000;
                     list_mask <= above_mask;
                     cmd_namespace_identifier <= next_first;
                     if (next_mode == MODE_DESC) begin
                        cmd_namespace_identifier <= namespace_identifier;
                     end
                  end
               end
            end
            ST_SEND: begin
               buf_valid <= 1'b1;
               buf_index <= word_count[9:0];
               buf_data <= next_word;
               buf_last <= (word_count[9:0] == `IDR_LAST_INDEX);
               if (mode == MODE_LIST) begin
                  list_mask <= list_rest;
               end
               word_count <= word_count + 11'h001;
               if (word_count[9:0] == `IDR_LAST_INDEX) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Event pulses for the interrupt status
   wire done_evt;
   wire abort_evt;
   assign done_evt = (state == ST_SEND) & (word_count[9:0] == `IDR_LAST_INDEX);
   assign abort_evt = (state == ST_IDLE) & start_req & (next_status != `IDR_STATUS_OK);

   // Sticky status, write one to clear; a new event wins over the clear
   reg [1:0] clr_bits;
   always @* begin
      clr_bits = 2'b00;
      if (wr_now & (ph_addr == `IDR_REG_INT_STATUS)) begin
         clr_bits = hwdata[1:0];
      end
   end

   always @(posedge clock) begin
      if (reset) begin
         int_status <= 2'b00;
         irq <= 1'b0;
      end else begin
         int_status[`IDR_INT_DONE] <= done_evt |
            (int_status[`IDR_INT_DONE] & ~clr_bits[`IDR_INT_DONE]);
         int_status[`IDR_INT_ABORT] <= abort_evt |
            (int_status[`IDR_INT_ABORT] & ~clr_bits[`IDR_INT_ABORT]);
         irq <= |(int_status & int_mask);
      end
   end
endmodule
`default_nettype wire

// file: test/idr_props.sv
`timescale 1ns/1ps
`default_nettype none
module idr_props (
   input wire clock,
   input wire reset,
   input wire hreadyout,
   input wire hresp,
   input wire buf_valid,
   input wire [9:0] buf_index,
   input wire [31:0] buf_data,
   input wire buf_last
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // Bus never stalls and never errors
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   a_ready_high: assert property (hreadyout == 1'b1)
      else $error("wait state seen");
   // Buffer words run 0 to 1023, one per cycle, then stop
   a_start_zero: assert property ($rose(buf_valid) |-> buf_index == 10'h0)
      else $error("buffer not starting at word 0");
   a_index_step: assert property (buf_valid && !buf_last |=>
      buf_valid && buf_index == $past(buf_index) + 10'h1)
      else $error("buffer word skipped or stopped early");
   a_last_index: assert property (buf_last |-> buf_valid && buf_index == 10'h3ff)
      else $error("last marker off the final word");
   a_end_after: assert property (buf_last |=> !buf_valid)
      else $error("buffer runs past 4096 bytes");
   a_run_length: assert property ($fell(buf_valid) |-> $past(buf_last))
      else $error("buffer ended without the last word");
   // No list holds more than 32 entries here, so the tail is zero
   a_tail_zero: assert property (buf_valid && buf_index > 10'h1f |-> buf_data == 32'h0)
      else $error("nonzero word in the fill area");
   a_zero_stays: assert property (buf_valid && !buf_last && buf_data == 32'h0 |=>
      buf_data == 32'h0)
      else $error("data after the zero fill began");
endmodule
bind idr_responder idr_props i_props (
   .clock(clock),
   .reset(reset),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .buf_valid(buf_valid),
   .buf_index(buf_index),
   .buf_data(buf_data),
   .buf_last(buf_last)
);
`default_nettype wire

// file: test/idr_host_sink.sv
`timescale 1ns/1ps
`default_nettype none
module idr_host_sink (
   input wire clock,
   input wire buf_valid,
   input wire [9:0] buf_index,
   input wire [31:0] buf_data,
   input wire buf_last
);
   logic [31:0] mem [0:1023];
   int frames = 0;
   int words = 0;
   logic tail_nz = 1'b0;
   // Host buffer: store words, count them, note data beyond word 2
   always @(posedge clock) begin
      if (buf_valid === 1'b1) begin
         mem[buf_index] <= buf_data;
         words <= (buf_index == 10'h0) ? 1 : words + 1;
         if (buf_index == 10'h0)
            tail_nz <= 1'b0;
         else if (buf_index > 10'h2 && buf_data !== 32'h0)
            tail_nz <= 1'b1;
         if (buf_last === 1'b1)
            frames <= frames + 1;
      end
   end
   // Walk descriptors; count only the types the host knows
   function automatic int known_desc();
      int p;
      int n;
      p = 0;
      n = 0;
      while (p < 1024 && mem[p][15:8] != 8'h0) begin
         if (mem[p][7:0] >= 8'h01 && mem[p][7:0] <= 8'h03)
            n++;
         p = p + 1 + mem[p][15:10];
      end
      return n;
   endfunction
endmodule
`default_nettype wire

// file: test/idr_responder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module idr_responder_tb_top;
   logic clock, reset, hsel, hwrite;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [1:0] msk;
   wire [31:0] hrdata, buf_data;
   wire hreadyout, hresp, buf_valid, buf_last, irq;
   wire [9:0] buf_index;
   wire hready = hreadyout;
   int miscompares = 0;
   int n_tests = 0;
   idr_responder i_dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .buf_valid(buf_valid),
      .buf_index(buf_index), .buf_data(buf_data), .buf_last(buf_last), .irq(irq));
   idr_host_sink i_host (.clock(clock), .buf_valid(buf_valid), .buf_index(buf_index),
      .buf_data(buf_data), .buf_last(buf_last));
   // 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task close_out;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Wait for an edge with hready high, bounded
   task automatic hold;
      int i;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (hready !== 1'b1 && i < 20);
      if (hready !== 1'b1) begin
         miscompares++;
         $display("ERROR %0t bus wait ran out", $time);
         close_out;
      end
   endtask
   // One single-word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hold;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold;
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask
   // Issue one identify request and check completion, buffer and interrupt
   task automatic run(input logic [7:0] sel, input logic [31:0] id, input logic [7:0] code,
      input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] e2);
      logic [31:0] r;
      logic [1:0] ev;
      int f;
      int i;
      f = i_host.frames;
      ev = (code == 8'h0) ? 2'h1 : 2'h2;
      wr(8'h04, {24'h0, sel});
      wr(8'h08, id);
      wr(8'h00, 32'h1);
      i = 0;
      do begin
         rd(8'h14, r);
         i++;
      end while (r[0] !== 1'b0 && i < 700);
      if (i >= 700) begin
         miscompares++;
         $display("ERROR %0t command never finished", $time);
         close_out;
      end
      chk({24'h0, r[15:8]}, {24'h0, code});
      chk(i_host.frames - f, {31'h0, code == 8'h0});
      if (code == 8'h0) begin
         chk(i_host.mem[0], e0);
         chk(i_host.mem[1], e1);
         chk(i_host.mem[2], e2);
         chk(i_host.words, 32'd1024);
         chk({31'h0, i_host.tail_nz}, 32'h0);
      end
      rd(8'h18, r);
      chk(r, {30'h0, ev});
      chk({31'h0, irq}, {31'h0, |(ev & msk)});
      wr(8'h18, r);
      rd(8'h18, r);
      chk(r, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask
   initial begin
      reset = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      msk = 2'h1;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      // Reset values, write-only start and an unmapped address read zero
      for (int a = 0; a < 9; a++) begin
         rd(a * 4, q);
         chk(q, 32'h0);
      end
      wr(8'h40, 32'hffffffff);
      rd(8'h40, q);
      chk(q, 32'h0);
      wr(8'h1c, 32'h1);
      wr(8'h0c, 32'h80000005);
      run(8'h00, 32'hffffffff, 8'h0b, 0, 0, 0);
      msk = 2'h3;
      wr(8'h1c, 32'h3);
      wr(8'h10, 32'h1);
      run(8'h00, 32'hffffffff, 8'h00, 32'h0000c0de, 0, 0);
      run(8'h00, 32'h1, 8'h00, 32'h00001000, 0, 0);
      run(8'h00, 32'h2, 8'h00, 0, 0, 0);
      run(8'h01, 32'h5, 8'h00, 32'h00005a5a, 0, 0);
      run(8'h02, 32'h0, 8'h00, 32'h1, 32'h3, 32'h20);
      run(8'h02, 32'h3, 8'h00, 32'h20, 0, 0);
      run(8'h02, 32'hffffffff, 8'h0b, 0, 0, 0);
      run(8'h02, 32'hfffffffe, 8'h0b, 0, 0, 0);
      run(8'h03, 32'h3, 8'h00, 32'h00000801, 32'h3, 32'h00a1b2c3);
      chk(i_host.known_desc(), 32'h1);
      run(8'h03, 32'h2, 8'h0b, 0, 0, 0);
      for (int s = 4; s < 16; s++)
         run(s, 32'h1, 8'h02, 0, 0, 0);
      run(8'h10, 32'h1, 8'h02, 0, 0, 0);
      run(8'hff, 32'h1, 8'h02, 0, 0, 0);
      close_out;
   end
endmodule
`default_nettype wire
